/* File: rtl/mdiv_core.sv */
// Multiply, divide, shift and normalize co-processor behind SFR registers.
`timescale 1ns/1ps

// Notes on behaviour
// - All operands and results are unsigned.
// - Byte 5 (once an operation is selected) or control write launches calculation.
// - Byte 2 or 3 written selects 32/16 division.
// - Byte 4 selects 16/16 division, byte 1 multiply.
// - Division and multiply take 17, 9, 11 cycles.
// - Shift takes 3 to 18 cycles.
// - Normalize takes 3 to 19 cycles.
// - Results read any order; final read ends.
// - Quotient low bytes, remainder bytes 4 and 5.
// - Zero shift count selects normalize, else shift.
// - Normalize shifts left, stores shift count.
// - Direction bit picks left or right, zero fill.
// - Byte 0 write arms, final read disarms.
// - Write during execution sets error; aborts unless it launches.
// - Armed byte read during execution sets error only.
// - Error flag read-only, cleared by control read.
// - Overflow on zero divisor, big product, normalized.
// - Other operations clear overflow; writes ignored.
module mdiv_core (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    // Special function register port.
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_rd_in,
    output logic [7:0] sfr_rdata_out,
    output logic sfr_hit_out,
    // Status.
    output logic busy_out
);
    import mdiv_pkg::*;

    // Operand and result bytes, control fields and flags.
    logic [7:0] byte_ff [6];
    logic dir_right_ff;
    logic [4:0] shift_count_ff;
    logic err_ff;
    logic ovf_ff;
    logic armed_ff;
    logic [7:0] rdata_ff;
    mdiv_op_t op_sel_ff;
    mdiv_op_t cur_op_ff;
    mdiv_phase_t phase_ff;
    mdiv_phase_t nxt_phase;

    // Decoded accesses.
    logic [2:0] idx;
    logic wr_byte;
    logic wr_ctrl;
    logic rd_byte;
    logic rd_ctrl;
    logic launch;
    logic abort;
    logic final_rd;
    mdiv_op_t launch_op;
    mdiv_op_t timer_op;

    // Timer and datapath connections.
    logic busy;
    logic done;
    logic [31:0] value;
    logic [15:0] divisor;
    logic [31:0] result;
    logic [15:0] remainder;
    logic res_ovf;
    logic [4:0] norm_cnt;

    // Map an address onto a byte index, the control index or no hit.
    function automatic logic [2:0] sfr_index(input logic [7:0] addr);
        case (addr)
            ADDR_BYTE0: return 3'h0;
            ADDR_BYTE1: return 3'h1;
            ADDR_BYTE2: return 3'h2;
            ADDR_BYTE3: return 3'h3;
            ADDR_BYTE4: return 3'h4;
            ADDR_BYTE5: return 3'h5;
            ADDR_CTRL: return IDX_CTRL;
            default: return IDX_NONE;
        endcase
    endfunction

    // Division operations end on the remainder high byte.
    function automatic logic is_div(input mdiv_op_t op);
        return (op == OP_DIV32) || (op == OP_DIV16);
    endfunction

    // Address decode and strobes.
    assign idx = sfr_index(sfr_addr_in);
    assign sfr_hit_out = (idx != IDX_NONE);
    assign wr_byte = sfr_wr_in && (idx < IDX_CTRL);
    assign wr_ctrl = sfr_wr_in && (idx == IDX_CTRL);
    assign rd_byte = sfr_rd_in && (idx < IDX_CTRL);
    assign rd_ctrl = sfr_rd_in && (idx == IDX_CTRL);

    // The 32-bit working value and the 16-bit second operand.
    assign value = {byte_ff[3], byte_ff[2], byte_ff[1], byte_ff[0]};
    assign divisor = {byte_ff[5], byte_ff[4]};

    // A control write launches shift or normalize from the new count.
    always_comb begin
        if (wr_ctrl) begin
            if (sfr_wdata_in[CTRL_CNT_MSB:0] == 5'h00) begin
                launch_op = OP_NORM;
            end else begin
                launch_op = OP_SHIFT;
            end
        end else begin
            launch_op = op_sel_ff;
        end
    end

    // Byte 5 launches only once the write order picked an operation.
    assign launch = wr_ctrl || (wr_byte && (idx == 3'h5) && (op_sel_ff != OP_NONE));

    // Any other write during execution interrupts the running operation.
    assign abort = busy && sfr_wr_in && sfr_hit_out && !launch;

    // The final result read depends on the kind of calculation.
    assign final_rd = rd_byte && !busy && (phase_ff == PH_READ) &&
                      (is_div(cur_op_ff) ? (idx == 3'h5) : (idx == 3'h3));

    // The timer is loaded with the operation being launched, otherwise it gets the running one.
    assign timer_op = launch ? launch_op : cur_op_ff;

    // Cycle timing of the running operation.
    mdiv_op_timer u_timer (
        .core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .start_in(launch),
        .abort_in(abort),
        .op_in(timer_op),
        .shift_count_in(sfr_wdata_in[CTRL_CNT_MSB:0]),
        .norm_cnt_in(norm_cnt),
        .busy_out(busy),
        .done_out(done)
    );

    // Result arithmetic, sampled on completion.
    mdiv_arith u_arith (
        .op_in(cur_op_ff),
        .value_in(value),
        .divisor_in(divisor),
        .shift_count_in(shift_count_ff),
        .dir_right_in(dir_right_ff),
        .result_out(result),
        .remainder_out(remainder),
        .ovf_out(res_ovf),
        .norm_cnt_out(norm_cnt)
    );

    // Next calculation phase.
    always_comb begin
        nxt_phase = phase_ff;
        case (phase_ff)
            PH_IDLE: begin
                if (launch) begin
                    nxt_phase = PH_EXEC;
                end else if (wr_byte && (idx == 3'h0)) begin
                    nxt_phase = PH_LOAD;
                end
            end
            PH_LOAD: begin
                if (launch) begin
                    nxt_phase = PH_EXEC;
                end
            end
            PH_EXEC: begin
                if (launch) begin
                    nxt_phase = PH_EXEC;
                end else if (abort) begin
                    nxt_phase = PH_LOAD;
                end else if (done) begin
                    nxt_phase = PH_READ;
                end
            end
            PH_READ: begin
                if (launch) begin
                    nxt_phase = PH_EXEC;
                end else if (wr_byte && (idx == 3'h0)) begin
                    nxt_phase = PH_LOAD;
                end else if (final_rd) begin
                    nxt_phase = PH_IDLE;
                end
            end
            default: begin
                nxt_phase = PH_IDLE;
            end
        endcase
    end

    // Phase register.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            phase_ff <= PH_IDLE;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    // Error detection is armed by byte 0 and disarmed by the final read.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            armed_ff <= 1'b0;
        end else if (wr_byte && (idx == 3'h0)) begin
            armed_ff <= 1'b1;
        end else if (final_rd) begin
            armed_ff <= 1'b0;
        end
    end

    // Track the write order that selects the next operation.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            op_sel_ff <= OP_NONE;
        end else if (launch) begin
            op_sel_ff <= OP_NONE;
        end else if (wr_byte) begin
            case (idx)
                3'h0: begin
                    op_sel_ff <= OP_NONE;
                end
                3'h1: begin
                    if (op_sel_ff != OP_DIV32) begin
                        op_sel_ff <= OP_MUL;
                    end
                end
                3'h2, 3'h3: begin
                    op_sel_ff <= OP_DIV32;
                end
                3'h4: begin
                    if (op_sel_ff != OP_DIV32) begin
                        op_sel_ff <= OP_DIV16;
                    end
                end
                default: begin
                    op_sel_ff <= op_sel_ff;
                end
            endcase
        end
    end

    // Remember the operation that was launched last.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cur_op_ff <= OP_NONE;
        end else if (launch) begin
            cur_op_ff <= launch_op;
        end
    end

    // Error flag: a set in the same cycle as the clearing read wins.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            err_ff <= 1'b0;
        end else if (busy && sfr_wr_in && sfr_hit_out) begin
            err_ff <= 1'b1;
        end else if (busy && rd_byte && armed_ff) begin
            err_ff <= 1'b1;
        end else if (rd_ctrl) begin
            err_ff <= 1'b0;
        end
    end

    // Overflow flag follows each completed operation and ignores writes.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ovf_ff <= 1'b0;
        end else if (done) begin
            ovf_ff <= res_ovf;
        end
    end

    // Direction and shift count; normalize reports its shift count.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            dir_right_ff <= CTRL_RESET[CTRL_DIR_BIT];
            shift_count_ff <= CTRL_RESET[CTRL_CNT_MSB:0];
        end else if (wr_ctrl) begin
            dir_right_ff <= sfr_wdata_in[CTRL_DIR_BIT];
            shift_count_ff <= sfr_wdata_in[CTRL_CNT_MSB:0];
        end else if (done && (cur_op_ff == OP_NORM)) begin
            shift_count_ff <= norm_cnt;
        end
    end

    // Operand storage; completion overwrites operands with results unless a division overflows.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < 6; i++) begin
                byte_ff[i] <= BYTE_RESET;
            end
        end else if (wr_byte) begin
            byte_ff[idx] <= sfr_wdata_in;
        end else if (done) begin
            case (cur_op_ff)
                OP_DIV32, OP_DIV16: begin
                    if (!res_ovf) begin
                        for (int i = 0; i < 4; i++) begin
                            byte_ff[i] <= result[8*i +: 8];
                        end
                        byte_ff[4] <= remainder[7:0];
                        byte_ff[5] <= remainder[15:8];
                    end
                end
                OP_MUL, OP_SHIFT, OP_NORM: begin
                    for (int i = 0; i < 4; i++) begin
                        byte_ff[i] <= result[8*i +: 8];
                    end
                end
                default: begin
                    byte_ff[0] <= byte_ff[0];
                end
            endcase
        end
    end

    // Read data is registered one cycle after the read strobe.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_ff <= 8'h00;
        end else if (rd_ctrl) begin
            rdata_ff <= {err_ff, ovf_ff, dir_right_ff, shift_count_ff};
        end else if (rd_byte) begin
            rdata_ff <= byte_ff[idx];
        end else if (sfr_rd_in) begin
            rdata_ff <= 8'h00;
        end
    end

    assign sfr_rdata_out = rdata_ff;
    assign busy_out = busy;
endmodule

/* File: rtl/mdiv_pkg.sv */
// Constants and types shared by the arithmetic co-processor.
package mdiv_pkg;

    // Register addresses on the special function register port.
    localparam logic [7:0] ADDR_BYTE0 = 8'he9;
    localparam logic [7:0] ADDR_BYTE1 = 8'hea;
    localparam logic [7:0] ADDR_BYTE2 = 8'heb;
    localparam logic [7:0] ADDR_BYTE3 = 8'hec;
    localparam logic [7:0] ADDR_BYTE4 = 8'hed;
    localparam logic [7:0] ADDR_BYTE5 = 8'hee;
    localparam logic [7:0] ADDR_CTRL = 8'hef;

    // Index codes produced by the address decoder.
    localparam logic [2:0] IDX_CTRL = 3'h6;
    localparam logic [2:0] IDX_NONE = 3'h7;

    // Control and status register layout and reset value.
    localparam int CTRL_ERR_BIT = 7;
    localparam int CTRL_OVF_BIT = 6;
    localparam int CTRL_DIR_BIT = 5;
    localparam int CTRL_CNT_MSB = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // Execution times in clock cycles.
    localparam logic [5:0] CYC_DIV32 = 6'h11;
    localparam logic [5:0] CYC_DIV16 = 6'h09;
    localparam logic [5:0] CYC_MUL = 6'h0b;
    localparam logic [5:0] CYC_SHIFT_BASE = 6'h02;
    localparam logic [5:0] CYC_NORM_BASE = 6'h03;

    // Largest product that does not raise the overflow flag.
    localparam logic [31:0] MUL_OVF_LIMIT = 32'h0000ffff;

    // Operation selected by the write order or by a control write.
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_DIV32 = 3'h1,
        OP_DIV16 = 3'h2,
        OP_MUL = 3'h3,
        OP_SHIFT = 3'h4,
        OP_NORM = 3'h5
    } mdiv_op_t;

    // Phases of one calculation, Gray coded along the usual path.
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_LOAD = 2'b01,
        PH_EXEC = 2'b11,
        PH_READ = 2'b10
    } mdiv_phase_t;

endpackage

/* File: rtl/mdiv_arith.sv */
// Combinational result, remainder and overflow for each operation.
`timescale 1ns/1ps
module mdiv_arith (
    // Operation and operands.
    input wire mdiv_pkg::mdiv_op_t op_in,
    input wire logic [31:0] value_in,
    input wire logic [15:0] divisor_in,
    input wire logic [4:0] shift_count_in,
    input wire logic dir_right_in,
    // Results.
    output logic [31:0] result_out,
    output logic [15:0] remainder_out,
    output logic ovf_out,
    output logic [4:0] norm_cnt_out
);
    import mdiv_pkg::*;

    // Leading zeros of the value, capped at the widest shift count.
    function automatic logic [4:0] lead_zeros(input logic [31:0] v);
        logic [4:0] n;
        n = 5'h1f;
        for (int i = 0; i < 32; i++) begin
            if (v[i]) begin
                n = 5'(31 - i);
            end
        end
        return n;
    endfunction

    // Count of left shifts that normalize the value.
    assign norm_cnt_out = lead_zeros(value_in);

    // All operands and results are treated as unsigned.
    always_comb begin
        result_out = value_in;
        remainder_out = divisor_in;
        ovf_out = 1'b0;
        case (op_in)
            OP_DIV32: begin
                if (divisor_in == 16'h0000) begin
                    ovf_out = 1'b1;
                end else begin
                    result_out = value_in / {16'h0000, divisor_in};
                    remainder_out = 16'(value_in % {16'h0000, divisor_in});
                end
            end
            OP_DIV16: begin
                if (divisor_in == 16'h0000) begin
                    ovf_out = 1'b1;
                end else begin
                    result_out = {16'h0000, value_in[15:0] / divisor_in};
                    remainder_out = value_in[15:0] % divisor_in;
                end
            end
            OP_MUL: begin
                result_out = {16'h0000, value_in[15:0]} * {16'h0000, divisor_in};
                ovf_out = (result_out > MUL_OVF_LIMIT);
            end
            OP_SHIFT: begin
                // Zeros enter at the vacated end.
                result_out = dir_right_in ? (value_in >> shift_count_in)
                                          : (value_in << shift_count_in);
            end
            OP_NORM: begin
                ovf_out = value_in[31];
                result_out = value_in << norm_cnt_out;
            end
            default: begin
                result_out = value_in;
            end
        endcase
    end
endmodule

/* File: rtl/mdiv_op_timer.sv */
// Cycle counter that times one operation from launch to completion.
`timescale 1ns/1ps
module mdiv_op_timer (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    // Launch and abort.
    input wire logic start_in,
    input wire logic abort_in,
    input wire mdiv_pkg::mdiv_op_t op_in,
    input wire logic [4:0] shift_count_in,
    input wire logic [4:0] norm_cnt_in,
    // Status.
    output logic busy_out,
    output logic done_out
);
    import mdiv_pkg::*;

    logic [5:0] cnt_ff;

    // Two bit positions are moved per cycle, so half the count rounded up.
    function automatic logic [5:0] half_up(input logic [4:0] n);
        return {2'b00, n[4:1]} + {5'h00, n[0]};
    endfunction

    // Length of each operation in cycles.
    function automatic logic [5:0] op_cycles(input mdiv_op_t op, input logic [4:0] sh,
                                             input logic [4:0] nc);
        case (op)
            OP_DIV32: return CYC_DIV32;
            OP_DIV16: return CYC_DIV16;
            OP_MUL: return CYC_MUL;
            OP_SHIFT: return CYC_SHIFT_BASE + half_up(sh);
            OP_NORM: return CYC_NORM_BASE + half_up(nc);
            default: return 6'h01;
        endcase
    endfunction

    // Load on launch, drop on abort, otherwise count down to zero.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_ff <= 6'h00;
        end else if (start_in) begin
            cnt_ff <= op_cycles(op_in, shift_count_in, norm_cnt_in);
        end else if (abort_in) begin
            cnt_ff <= 6'h00;
        end else if (cnt_ff != 6'h00) begin
            cnt_ff <= cnt_ff - 6'h01;
        end
    end

    assign busy_out = (cnt_ff != 6'h00);
    assign done_out = (cnt_ff == 6'h01) && !abort_in && !start_in;
endmodule

/* File: bench/mdiv_core_properties.sv */
// Concurrent checks on the register port of the co-processor.
`timescale 1ns/1ps
module mdiv_core_props (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    // Register port and status.
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic sfr_hit_out,
    input wire logic busy_out
);
    import mdiv_pkg::*;
    logic [5:0] busy_run_ff;
    logic launch_ctl;

    // All checks share the core clock and the asynchronous reset.
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    // A control write while idle launches a shift or normalize.
    assign launch_ctl = sfr_wr_in && sfr_addr_in == ADDR_CTRL && !busy_out;

    // Length of the current execution; any hit write starts a new count.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            busy_run_ff <= 6'h00;
        end else if (!busy_out || (sfr_wr_in && sfr_hit_out)) begin
            busy_run_ff <= 6'h00;
        end else begin
            busy_run_ff <= busy_run_ff + 6'h01;
        end
    end

    a_hit_decode: assert property (sfr_hit_out == (sfr_addr_in inside {[8'he9:8'hef]}))
        else $error("hit flag disagrees with address");
    a_unmapped_read_zero: assert property (sfr_rd_in && !sfr_hit_out |=> sfr_rdata_out == 8'h00)
        else $error("unmapped read returned data");
    a_rdata_holds: assert property (!sfr_rd_in |=> $stable(sfr_rdata_out))
        else $error("read data changed without a read");
    a_idle_readback: assert property (sfr_wr_in && sfr_hit_out && sfr_addr_in != ADDR_CTRL
        && !busy_out ##2 sfr_rd_in && sfr_addr_in == $past(sfr_addr_in, 2) && !busy_out
        |=> sfr_rdata_out == $past(sfr_wdata_in, 3))
        else $error("idle byte did not read back");
    a_err_on_write: assert property (sfr_wr_in && sfr_hit_out && busy_out
        ##2 sfr_rd_in && sfr_addr_in == ADDR_CTRL |=> sfr_rdata_out[CTRL_ERR_BIT])
        else $error("write during execution left error flag clear");
    a_launch_min_busy: assert property (launch_ctl |=> busy_out [*3])
        else $error("control launch ran under three cycles");
    a_shift_max_len: assert property (launch_ctl && sfr_wdata_in[4:0] == 5'h1f
        |=> ##17 busy_out ##1 !busy_out)
        else $error("longest shift not eighteen cycles");
    a_busy_bounded: assert property (busy_run_ff <= 6'h13)
        else $error("execution longer than nineteen cycles");

    // Main scenarios reached.
    c_ctrl_launch: cover property (launch_ctl);
    c_write_busy: cover property (sfr_wr_in && sfr_hit_out && busy_out);
    c_read_busy: cover property (sfr_rd_in && sfr_hit_out && busy_out);
endmodule

bind mdiv_core mdiv_core_props mdiv_core_props_i (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .sfr_addr_in(sfr_addr_in),
    .sfr_wr_in(sfr_wr_in),
    .sfr_wdata_in(sfr_wdata_in),
    .sfr_rd_in(sfr_rd_in),
    .sfr_rdata_out(sfr_rdata_out),
    .sfr_hit_out(sfr_hit_out),
    .busy_out(busy_out)
);

/* File: bench/mdiv_host_model.sv */
// Model of the controlling core issuing register accesses.
`timescale 1ns/1ps
module mdiv_host_model (
    // Clock.
    input wire logic core_clk_in,
    // Register port towards the co-processor.
    output logic [7:0] sfr_addr_out,
    output logic sfr_wr_out,
    output logic [7:0] sfr_wdata_out,
    output logic sfr_rd_out,
    input wire logic [7:0] sfr_rdata_in
);
    // Port idle at time zero.
    initial begin
        sfr_addr_out = 8'h00;
        sfr_wr_out = 1'b0;
        sfr_wdata_out = 8'h00;
        sfr_rd_out = 1'b0;
    end

    // One write held over its sampling edge, then one idle cycle.
    task automatic put(input logic [7:0] addr, input logic [7:0] data);
        sfr_addr_out = addr;
        sfr_wdata_out = data;
        sfr_wr_out = 1'b1;
        @(posedge core_clk_in);
        #1;
        sfr_wr_out = 1'b0;
        sfr_wdata_out = ~data; // Released data must not look still valid.
        @(posedge core_clk_in);
        #1;
    endtask

    // One read; data is taken one cycle after the strobe, as the core does.
    task automatic get(input logic [7:0] addr, output logic [7:0] data);
        sfr_addr_out = addr;
        sfr_rd_out = 1'b1;
        @(posedge core_clk_in);
        #1;
        sfr_rd_out = 1'b0;
        data = sfr_rdata_in;
        @(posedge core_clk_in);
        #1;
    endtask
endmodule

/* File: bench/tb.sv */
// Self-checking testbench for the multiply divide co-processor.
`timescale 1ns/1ps
module tb;
    import mdiv_pkg::*;
    logic clk, rst_n, wr, rd, hit, busy;
    logic [7:0] addr, wdata, rdata;
    logic [7:0] md [6];
    int miscompares = 0;
    int samples_checked = 0;

    // Clock at 200 MHz; reset held for 12 cycles.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        rst_n = 1'b0;
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
    end

    // Device and core model.
    mdiv_core mdiv_core_i (.core_clk_in(clk), .arst_n_in(rst_n), .sfr_addr_in(addr),
        .sfr_wr_in(wr), .sfr_wdata_in(wdata), .sfr_rd_in(rd), .sfr_rdata_out(rdata),
        .sfr_hit_out(hit), .busy_out(busy));
    mdiv_host_model mdiv_host_model_i (.core_clk_in(clk), .sfr_addr_out(addr),
        .sfr_wr_out(wr), .sfr_wdata_out(wdata), .sfr_rd_out(rd), .sfr_rdata_in(rdata));

    // Compare one seen value with the model value.
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Print the counts and the verdict, then stop.
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Register access by index; index 6 is the control register.
    task automatic wrb(input int i, input logic [7:0] d);
        mdiv_host_model_i.put(ADDR_BYTE0 + 8'(i), d);
        if (i < 6) md[i] = d;
    endtask
    task automatic rdb(input int i, output logic [7:0] d);
        mdiv_host_model_i.get(ADDR_BYTE0 + 8'(i), d);
    endtask

    // Load in the order that selects the operation, launch, time it, read back.
    task automatic run_op(input int op, input logic [31:0] a, input logic [15:0] b,
                          input logic [7:0] ctl, input bit midrd);
        logic [31:0] v, t;
        logic [15:0] r;
        logic [7:0] got;
        int n = 0;
        int cyc = 0;
        int lz = 0;
        bit ovf = 0;
        wrb(0, a[7:0]);
        if (op == 2) wrb(4, b[7:0]);
        wrb(1, a[15:8]);
        if (op == 0 || op > 2) begin
            wrb(2, a[23:16]);
            wrb(3, a[31:24]);
        end
        if (op < 2) wrb(4, b[7:0]);
        wrb(op < 3 ? 5 : 6, op < 3 ? b[15:8] : ctl);
        v = {md[3], md[2], md[1], md[0]};
        r = {md[5], md[4]};
        if (op == 1) v = v & 32'hffff;
        case (op)
            0, 1: begin
                cyc = op == 0 ? 17 : 9;
                ovf = r == 16'h0;
                if (!ovf) begin
                    t = v % r;
                    v = v / r;
                    r = t[15:0];
                end
            end
            2: begin
                cyc = 11;
                v = v[15:0] * r;
                ovf = v > 32'hffff;
            end
            3: begin
                cyc = 2 + (ctl[4:0] + 1) / 2;
                v = ctl[5] ? v >> ctl[4:0] : v << ctl[4:0];
            end
            default: begin
                ovf = v[31];
                while (!v[31] && lz < 31) begin
                    v = v << 1;
                    lz++;
                end
                cyc = 3 + (lz + 1) / 2;
            end
        endcase
        if (!(ovf && op < 2)) begin
            {md[3], md[2], md[1], md[0]} = v;
            if (op < 2) {md[5], md[4]} = r;
        end
        while (busy && n < 40) begin
            if (midrd && n == 2) begin
                rdb(0, got);
                n += 2;
            end else begin
                n++;
                @(posedge clk);
                #1;
            end
        end
        if (n >= 40) begin
            miscompares++;
            finish_test();
        end
        // The launch write's idle cycle already spent one busy cycle.
        check("busy cycles", n, cyc - 1);
        for (int i = 0; i <= (op < 2 ? 5 : 3); i++) begin
            rdb(i, got);
            check("result byte", got, md[i]);
        end
        rdb(6, got);
        check("flags", got[7:6], {midrd, ovf});
        if (op == 4) check("norm count", got[5:0], 6'(lz));
        $display("test op %0d done", op);
    endtask

    // Main sequence.
    initial begin
        logic [7:0] got;
        int op;
        void'($urandom(32'h1304));
        repeat (14) @(posedge clk);
        #1;
        for (int i = 0; i < 8; i++) begin
            rdb(i, got);
            check("reset value", got, 8'h00);
        end
        for (int i = 5; i >= 0; i--) begin
            wrb(i, 8'($urandom));
            rdb(i, got);
            check("stored byte", got, md[i]);
        end
        rdb(6, got);
        check("idle status", got, 8'h00);
        $display("test storage done");
        run_op(0, $urandom, 16'($urandom) | 16'h1, 8'h00, 0);
        run_op(0, $urandom, 16'h0000, 8'h00, 0);
        run_op(0, $urandom, 16'($urandom) | 16'h1, 8'h00, 1);
        run_op(1, $urandom, 16'($urandom) | 16'h1, 8'h00, 0);
        run_op(1, $urandom, 16'h0000, 8'h00, 0);
        run_op(2, 32'h00ff, 16'h0101, 8'h00, 0);
        run_op(2, 32'h0100, 16'h0100, 8'h00, 0);
        run_op(3, $urandom, 16'h0, 8'h01, 0);
        run_op(3, $urandom, 16'h0, 8'hff, 0);
        run_op(3, $urandom, 16'h0, 8'h1f, 0);
        run_op(4, 32'h0, 16'h0, 8'h00, 0);
        run_op(4, 32'h8000_0000, 16'h0, 8'hc0, 0);
        for (int k = 0; k < 12; k++) begin
            op = $urandom % 5;
            run_op(op, $urandom >> ($urandom % 32), 16'($urandom),
                op == 4 ? {2'($urandom), 6'h00} : {3'($urandom), 5'($urandom % 31 + 1)}, 0);
        end
        // A write in mid execution aborts and flags an error.
        wrb(0, 8'h81);
        wrb(6, 8'h1e);
        repeat (3) @(posedge clk);
        #1;
        wrb(0, 8'h42);
        check("busy after abort", busy, 1'b0);
        rdb(6, got);
        check("error set", got[7], 1'b1);
        rdb(6, got);
        check("error cleared", got[7], 1'b0);
        $display("test abort done");
        finish_test();
    end
endmodule
